/* File: pvp_port.v */
// Purpose: parallel data and video port between memory streams and external pins
// Assumes: port sample clock well below clk_i/4; config changed only while disabled
// Notes:   all pin traffic happens on rising edges of the sampled port clock
`timescale 1ns/1ns
`include "pvp_defs.vh"

module pvp_port #(
	parameter DW    = `PVP_DATA_W,
	parameter DEPTH = `PVP_FIFO_DEPTH,
	parameter AW    = `PVP_FIFO_AW
) (
	// clock and reset
	input  wire          clk_i,
	input  wire          reset_n_i,
	// configuration
	input  wire          enable_i,
	input  wire [1:0]    port_mode_i,
	input  wire [1:0]    video_submode_i,
	input  wire          video_ten_bit_i,
	input  wire [2:0]    data_width_i,
	input  wire [1:0]    out_sync_count_i,
	input  wire [15:0]   sync_to_data_delay_i,
	input  wire [15:0]   transfer_sample_count_i,
	input  wire [15:0]   frame_line_count_i,
	// external pins
	input  wire          port_sample_clock_i,
	input  wire [DW-1:0] port_data_i,
	output wire [DW-1:0] port_data_o,
	output wire          port_data_oe_o,
	input  wire [2:0]    frame_sync_i,
	output wire [2:0]    frame_sync_o,
	output wire [2:0]    frame_sync_oe_o,
	// received stream
	output wire [DW-1:0] rx_data_o,
	output wire          rx_valid_o,
	input  wire          rx_ready_i,
	// transmitted stream
	input  wire [DW-1:0] tx_data_i,
	input  wire          tx_valid_i,
	output wire          tx_ready_o,
	// status
	output wire          busy_o,
	output wire          video_locked_o,
	output wire          frame_done_o,
	output wire          overrun_o,
	output wire          underrun_o
);

	localparam [3:0] ST_IDLE  = 4'b0001;
	localparam [3:0] ST_ARM   = 4'b0010;
	localparam [3:0] ST_DELAY = 4'b0100;
	localparam [3:0] ST_XFER  = 4'b1000;

	function [DW-1:0] width_mask;
		input [2:0] sel;
		begin
			if (sel == `PVP_WIDTH_8) begin
				width_mask = `PVP_MASK_8;
			end else begin
				width_mask = ({DW{1'b1}} >> (DW - (`PVP_WIDTH_BASE + sel)));
			end
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; first stages feed only the second stages
	reg          pclk_s1_q;
	reg          pclk_s2_q;
	reg          pclk_s3_q;
	reg [2:0]    fs_s1_q;
	reg [2:0]    fs_s2_q;
	reg          fs1_prev_q;
	reg [DW-1:0] dat_s1_q;
	reg [DW-1:0] dat_s2_q;
	wire         tick;

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pclk_s1_q <= 1'b0;
			pclk_s2_q <= 1'b0;
			pclk_s3_q <= 1'b0;
			fs_s1_q   <= 3'h0;
			fs_s2_q   <= 3'h0;
			dat_s1_q  <= {DW{1'b0}};
			dat_s2_q  <= {DW{1'b0}};
		end else begin
			pclk_s1_q <= port_sample_clock_i;
			pclk_s2_q <= pclk_s1_q;
			pclk_s3_q <= pclk_s2_q;
			fs_s1_q   <= frame_sync_i;
			fs_s2_q   <= fs_s1_q;
			dat_s1_q  <= port_data_i;
			dat_s2_q  <= dat_s1_q;
		end
	end

	assign tick = pclk_s2_q & ~pclk_s3_q;

	////////////////////////////////////////////////////////////////////////
	// general-purpose sequencer
	reg  [3:0]    state_q;
	reg  [15:0]   cnt_q;
	reg  [15:0]   line_q;
	reg  [2:0]    fs_out_q;
	reg  [DW-1:0] dout_q;
	reg           gp_we_q;
	reg  [DW-1:0] gp_wd_q;
	reg           gp_done_q;
	reg           underrun_q;
	wire          is_in;
	wire          is_out;
	wire          gp_mode;
	wire [15:0]   cnt_inc;
	wire [15:0]   line_inc;
	wire          fs1_rise;
	wire [DW-1:0] mask;

	assign is_in    = (port_mode_i == `PVP_MODE_IN);
	assign is_out   = (port_mode_i == `PVP_MODE_OUT);
	assign gp_mode  = (port_mode_i != `PVP_MODE_ITU);
	assign cnt_inc  = cnt_q + 16'h0001;
	assign line_inc = line_q + 16'h0001;
	assign fs1_rise = fs_s2_q[0] & ~fs1_prev_q;
	assign mask     = width_mask(data_width_i);
	assign tx_ready_o = tick & is_out & (state_q == ST_XFER);

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_q    <= ST_IDLE;
			cnt_q      <= 16'h0000;
			line_q     <= 16'h0000;
			fs_out_q   <= 3'h0;
			dout_q     <= {DW{1'b0}};
			gp_we_q    <= 1'b0;
			gp_wd_q    <= {DW{1'b0}};
			gp_done_q  <= 1'b0;
			underrun_q <= 1'b0;
			fs1_prev_q <= 1'b0;
		end else begin
			gp_we_q   <= 1'b0;
			gp_done_q <= 1'b0;
			if (tick) begin
				fs1_prev_q <= fs_s2_q[0];
			end
			if (!enable_i || !gp_mode) begin
				state_q    <= ST_IDLE;
				fs_out_q   <= 3'h0;
				underrun_q <= 1'b0;
			end else begin
				case (state_q)
				ST_IDLE: begin
					state_q <= ST_ARM;
					cnt_q   <= 16'h0000;
					line_q  <= 16'h0000;
				end
				ST_ARM: begin
					if (tick && (!is_in || fs1_rise)) begin
						cnt_q <= 16'h0000;
						state_q <= (sync_to_data_delay_i == 16'h0000) ? ST_XFER : ST_DELAY;
						if (!is_in) begin
							fs_out_q[0] <= 1'b1;
							fs_out_q[1] <= (line_q == 16'h0000);
							fs_out_q[2] <= is_out & (sync_to_data_delay_i == 16'h0000);
						end
					end
				end
				ST_DELAY: begin
					if (tick) begin
						fs_out_q[1:0] <= 2'h0;
						cnt_q <= cnt_inc;
						if (cnt_inc == sync_to_data_delay_i) begin
							cnt_q       <= 16'h0000;
							state_q     <= ST_XFER;
							fs_out_q[2] <= is_out;
						end
					end
				end
				ST_XFER: begin
					if (tick) begin
						fs_out_q[1:0] <= 2'h0;
						cnt_q <= cnt_inc;
						if (is_out) begin
							if (tx_valid_i) begin
								dout_q <= tx_data_i & mask;
							end else begin
								underrun_q <= 1'b1;
							end
						end else begin
							gp_we_q <= 1'b1;
							gp_wd_q <= dat_s2_q & mask;
						end
						if (cnt_inc == transfer_sample_count_i) begin
							cnt_q       <= 16'h0000;
							state_q     <= ST_ARM;
							fs_out_q[2] <= 1'b0;
							if (is_in || line_inc == frame_line_count_i) begin
								line_q    <= 16'h0000;
								gp_done_q <= 1'b1;
							end else begin
								line_q <= line_inc;
							end
						end
					end
				end
				default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

	// drivers follow the submode; input submode drives nothing
	assign port_data_o     = dout_q;
	assign port_data_oe_o  = enable_i & is_out;
	assign frame_sync_o    = fs_out_q;
	assign frame_sync_oe_o = (enable_i && port_mode_i == `PVP_MODE_CAPTURE) ? 3'b011 :
		(enable_i && is_out) ? ((3'b111 >> (2'h3 - out_sync_count_i)) & 3'b111) : 3'h0;

	////////////////////////////////////////////////////////////////////////
	// video decoder: three-deep delay line lets a preamble be struck after the fact
	reg  [9:0] p0_q;
	reg  [9:0] p1_q;
	reg  [9:0] p2_q;
	reg  [2:0] keep_q;
	reg        lock_q;
	reg        field_q;
	reg        vblank_q;
	reg        active_q;
	reg [15:0] vlines_q;
	reg        v_we_q;
	reg  [9:0] v_wd_q;
	reg        v_done_q;
	wire [9:0] smp;
	wire [9:0] ones;
	wire [7:0] xy;
	wire       det;
	wire       new_lock;
	wire       filt;
	wire       win;
	wire       keep_now;
	wire       sub_field;
	wire       itu_run;

	assign itu_run   = enable_i & (port_mode_i == `PVP_MODE_ITU);
	assign smp       = video_ten_bit_i ? dat_s2_q[9:0] : {2'b00, dat_s2_q[7:0]};
	assign ones      = video_ten_bit_i ? `PVP_PRE_ONES_10 : `PVP_PRE_ONES_8;
	assign xy        = video_ten_bit_i ? smp[9:2] : smp[7:0];
	assign det       = (p2_q == ones) && (p1_q == `PVP_PRE_ZERO) && (p0_q == `PVP_PRE_ZERO);
	assign sub_field = (video_submode_i == `PVP_ITU_FIELD);
	assign new_lock  = det & field_q & ~xy[`PVP_XY_F] & ~lock_q;
	assign filt      = det & ~sub_field;
	assign win       = sub_field ? 1'b1 :
		(video_submode_i == `PVP_ITU_VBI) ? vblank_q : active_q;
	assign keep_now  = det ? (sub_field & (lock_q | new_lock)) : (lock_q & win);

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			p0_q     <= `PVP_PRE_ZERO;
			p1_q     <= `PVP_PRE_ZERO;
			p2_q     <= `PVP_PRE_ZERO;
			keep_q   <= 3'h0;
			lock_q   <= 1'b0;
			field_q  <= 1'b0;
			vblank_q <= 1'b0;
			active_q <= 1'b0;
			vlines_q <= 16'h0000;
			v_we_q   <= 1'b0;
			v_wd_q   <= `PVP_PRE_ZERO;
			v_done_q <= 1'b0;
		end else begin
			v_we_q   <= 1'b0;
			v_done_q <= 1'b0;
			if (!itu_run) begin
				keep_q   <= 3'h0;
				lock_q   <= 1'b0;
				field_q  <= 1'b0;
				active_q <= 1'b0;
				vblank_q <= 1'b0;
			end else if (tick) begin
				v_we_q <= keep_q[2] & ~filt;
				v_wd_q <= p2_q;
				p2_q   <= p1_q;
				p1_q   <= p0_q;
				p0_q   <= smp;
				keep_q <= {keep_q[1:0], keep_now} & {3{~filt}};
				if (det) begin
					field_q  <= xy[`PVP_XY_F];
					vblank_q <= xy[`PVP_XY_V];
					// opens only on a start code outside vertical blanking
					active_q <= ~xy[`PVP_XY_H] & ~xy[`PVP_XY_V];
					if (new_lock) begin
						lock_q   <= 1'b1;
						vlines_q <= 16'h0000;
						active_q <= 1'b0;
					end
					if (lock_q && video_submode_i == `PVP_ITU_ACTIVE && active_q && xy[`PVP_XY_H]) begin
						vlines_q <= vlines_q + 16'h0001;
						if (vlines_q + 16'h0001 == transfer_sample_count_i) begin
							lock_q   <= 1'b0;
							v_done_q <= 1'b1;
						end
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// received words queue; a full queue loses the word and flags it
	reg           overrun_q;
	wire          fifo_ready;
	wire          wr_valid;
	wire [DW-1:0] wr_data;

	assign wr_valid = gp_we_q | v_we_q;
	assign wr_data  = gp_we_q ? gp_wd_q : {{(DW-10){1'b0}}, v_wd_q};

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overrun_q <= 1'b0;
		end else if (wr_valid && !fifo_ready) begin
			overrun_q <= 1'b1;
		end else if (!enable_i) begin
			overrun_q <= 1'b0;
		end
	end

	pvp_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH),
		.AW    (AW)
	) u_fifo (
		.clk_i       (clk_i),
		.reset_n_i   (reset_n_i),
		.in_data_i   (wr_data),
		.in_valid_i  (wr_valid),
		.in_ready_o  (fifo_ready),
		.out_data_o  (rx_data_o),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i)
	);

	assign busy_o         = (state_q != ST_IDLE) | lock_q;
	assign video_locked_o = lock_q;
	assign frame_done_o   = gp_done_q | v_done_q;
	assign overrun_o      = overrun_q;
	assign underrun_o     = underrun_q;

endmodule

/* File: pvp_defs.vh */
// Purpose: shared constants of the parallel video port
// Assumes: included by every file of the port
// Notes:   definitions only
`ifndef PVP_DEFS_VH
`define PVP_DEFS_VH

// general-purpose submodes and the video mode
`define PVP_MODE_IN       2'h0
`define PVP_MODE_CAPTURE  2'h1
`define PVP_MODE_OUT      2'h2
`define PVP_MODE_ITU      2'h3

// video submodes
`define PVP_ITU_ACTIVE    2'h0
`define PVP_ITU_VBI       2'h1
`define PVP_ITU_FIELD     2'h2

// data width codes and masks
`define PVP_WIDTH_8       3'h0
`define PVP_WIDTH_BASE    5'h09
`define PVP_MASK_8        16'h00FF
`define PVP_MASK_10       16'h03FF

// embedded preamble words
`define PVP_PRE_ONES_8    10'h0FF
`define PVP_PRE_ONES_10   10'h3FF
`define PVP_PRE_ZERO      10'h000

// bits of the status word after a preamble
`define PVP_XY_F          6
`define PVP_XY_V          5
`define PVP_XY_H          4

// sizes
`define PVP_DATA_W        16
`define PVP_FIFO_DEPTH    8
`define PVP_FIFO_AW       3
`define PVP_FS_COUNT      3

`endif

/* File: pvp_fifo.v */
// Purpose: small synchronous fifo in the received data path
// Assumes: one clock, writer and reader both on clk_i
// Notes:   full and empty are exact; no write while full, no read while empty
`timescale 1ns/1ns
`include "pvp_defs.vh"

module pvp_fifo #(
	parameter WIDTH = `PVP_DATA_W,
	parameter DEPTH = `PVP_FIFO_DEPTH,
	parameter AW    = `PVP_FIFO_AW
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             reset_n_i,
	// filling side
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	// draining side
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      level_q;
	wire            push;
	wire            pop;

	assign in_ready_o  = (level_q != DEPTH[AW:0]);
	assign out_valid_o = (level_q != {(AW+1){1'b0}});
	assign out_data_o  = mem_q[rd_ptr_q];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end

	// pointers wrap by depth so a depth that is not a power of two still works
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			level_q  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				level_q <= level_q + 1'b1;
			end else if (pop && !push) begin
				level_q <= level_q - 1'b1;
			end
		end
	end

endmodule

/* File: pvp_port_asserts.sv */
// Purpose: concurrent checks on the parallel video port pins and streams
// Assumes: one clock domain; config steady while enabled
// Notes:   tick mirrors a two-flop sync of the port clock, so pin moves get two cycles of slack
`timescale 1ns/1ns
`include "pvp_defs.vh"
module pvp_port_asserts #(
	parameter DW = 16
) (
	// clock and reset
	input wire          clk_i,
	input wire          reset_n_i,
	// configuration
	input wire          enable_i,
	input wire [1:0]    port_mode_i,
	input wire [2:0]    data_width_i,
	input wire [1:0]    out_sync_count_i,
	// pins
	input wire          port_sample_clock_i,
	input wire [DW-1:0] port_data_o,
	input wire          port_data_oe_o,
	input wire [2:0]    frame_sync_o,
	input wire [2:0]    frame_sync_oe_o,
	// streams and status
	input wire [DW-1:0] rx_data_o,
	input wire          rx_valid_o,
	input wire          tx_ready_o,
	input wire          frame_done_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	////////////////////////////////////////////////////////////////////////
	logic [2:0] sync_q;
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			sync_q <= 3'h0;
		else
			sync_q <= {sync_q[1:0], port_sample_clock_i};
	end
	wire        tick  = sync_q[1] & ~sync_q[2];
	wire [15:0] wmask = (data_width_i == 3'h0) ? 16'h00FF : (16'hFFFF >> (3'h7 - data_width_i));
	sequence beat(s);
		s ##1 !s;
	endsequence
	a_input_listens: assert property (enable_i && port_mode_i == `PVP_MODE_IN |->
		!port_data_oe_o && frame_sync_oe_o == 3'h0) else $error("input mode drives a pin");
	a_capture_dirs: assert property (enable_i && port_mode_i == `PVP_MODE_CAPTURE |->
		!port_data_oe_o && frame_sync_oe_o == 3'h3) else $error("capture mode pin directions wrong");
	a_output_dirs: assert property (enable_i && port_mode_i == `PVP_MODE_OUT |->
		port_data_oe_o && frame_sync_oe_o == ((3'h1 << out_sync_count_i) - 3'h1)) else $error("output enables wrong");
	a_hsync_vsync: assert property (enable_i && port_mode_i == `PVP_MODE_CAPTURE && frame_sync_o[1]
		|-> frame_sync_o[0]) else $error("frame sync without line sync");
	a_half_duplex: assert property (port_data_oe_o |-> enable_i && port_mode_i == `PVP_MODE_OUT)
		else $error("data driven outside output mode");
	a_pins_on_tick: assert property (enable_i && $past(enable_i) && !$stable({port_data_o, frame_sync_o})
		|-> $past(tick) || $past(tick, 2)) else $error("pin output moved off a port tick");
	a_tx_beat: assert property (tx_ready_o |-> port_mode_i == `PVP_MODE_OUT ##0 beat(tx_ready_o))
		else $error("tx ready not a single beat");
	a_done_beat: assert property (frame_done_o |-> beat(frame_done_o))
		else $error("frame done not a single beat");
	a_width_mask: assert property (rx_valid_o && enable_i && port_mode_i[1] == 1'b0
		|-> (rx_data_o & ~wmask) == 16'h0000) else $error("received word wider than set width");
endmodule
bind pvp_port pvp_port_asserts #(.DW(DW)) u_pvp_port_asserts (.clk_i(clk_i), .reset_n_i(reset_n_i),
	.enable_i(enable_i), .port_mode_i(port_mode_i), .data_width_i(data_width_i),
	.out_sync_count_i(out_sync_count_i), .port_sample_clock_i(port_sample_clock_i), .port_data_o(port_data_o),
	.port_data_oe_o(port_data_oe_o), .frame_sync_o(frame_sync_o), .frame_sync_oe_o(frame_sync_oe_o),
	.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .tx_ready_o(tx_ready_o), .frame_done_o(frame_done_o));

/* File: pvp_src_model.sv */
// Purpose: far-side source and port clock for the port pins
// Assumes: port clock period of 160 ns or longer
// Notes:   clock rests low between calls; a released bus shows inverted data, not a stale value
`timescale 1ns/1ns
module pvp_src_model (
	// pins toward the port
	output logic        pclk_o,
	output logic [15:0] data_o,
	output logic [2:0]  fs_o
);
	initial begin
		pclk_o = 1'b0;
		data_o = 16'h0000;
		fs_o   = 3'h0;
	end
	////////////////////////////////////////////////////////////////////////
	// pins set well before the rise and held past it; slow stretches the low half
	task automatic tick(input logic [15:0] d, input logic fs1, input int slow);
		data_o = d;
		fs_o   = {2'b00, fs1};
		#(80 + slow) pclk_o = 1'b1;
		#80 pclk_o = 1'b0;
	endtask
	task automatic release_bus();
		data_o = ~data_o;
		fs_o   = 3'h0;
	endtask
endmodule

/* File: pvp_port_tb.sv */
// Purpose: directed bench for the parallel video port
// Assumes: config changed only while disabled, except video_ten_bit_i set just before cfg; rx drained before each mode switch
// Notes:   port clock runs only inside test calls; each input frame has an idle tick either side
`timescale 1ns/1ns
`include "pvp_defs.vh"
module pvp_port_tb;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        enable_i = 1'b0;
	logic [1:0]  port_mode_i = 2'h0;
	logic [1:0]  video_submode_i = 2'h0;
	logic        video_ten_bit_i = 1'b0;
	logic [2:0]  data_width_i = 3'h0;
	logic [1:0]  out_sync_count_i = 2'h3;
	logic [15:0] sync_to_data_delay_i = 16'h0000;
	logic [15:0] transfer_sample_count_i = 16'h0001;
	logic [15:0] frame_line_count_i = 16'h0001;
	logic        rx_ready_i = 1'b1;
	logic [15:0] tx_data_i = 16'h1234;
	logic        tx_valid_i = 1'b0;
	logic        shown_q = 1'b0;
	wire         port_sample_clock_i, port_data_oe_o, rx_valid_o, tx_ready_o, video_locked_o;
	wire         frame_done_o, overrun_o, underrun_o, busy_o;
	int          n_hs = 0;
	int          n_vs = 0;
	int          n_fe = 0;
	logic [2:0]  fs_prev_q = 3'h0;
	// blanking-interval stream: lock arrives inside vertical blanking, active start closes it
	localparam logic [7:0] VB [0:18] = '{8'hFF, 8'h00, 8'h00, 8'hE0, 8'hFF, 8'h00, 8'h00, 8'hA0, 8'h31, 8'h32,
		8'h33, 8'h34, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h41, 8'h42, 8'h43};
	wire  [15:0] port_data_i, port_data_o, rx_data_o;
	wire  [2:0]  frame_sync_i, frame_sync_o, frame_sync_oe_o;
	int          n_fail = 0;
	int          comparisons = 0;
	int          n_done = 0;
	int          cyc = 0;
	logic [15:0] rxq[$];
	logic [15:0] txq[$];
	localparam logic [7:0] VS [0:20] = '{8'hFF, 8'h00, 8'h00, 8'hC0, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h10, 8'h20,
		8'hFF, 8'h00, 8'h00, 8'h80, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
	pvp_port u_pvp_port (.clk_i(clk_i), .reset_n_i(reset_n_i), .enable_i(enable_i), .port_mode_i(port_mode_i),
		.video_submode_i(video_submode_i), .video_ten_bit_i(video_ten_bit_i), .data_width_i(data_width_i),
		.out_sync_count_i(out_sync_count_i), .sync_to_data_delay_i(sync_to_data_delay_i),
		.transfer_sample_count_i(transfer_sample_count_i), .frame_line_count_i(frame_line_count_i),
		.port_sample_clock_i(port_sample_clock_i), .port_data_i(port_data_i), .port_data_o(port_data_o),
		.port_data_oe_o(port_data_oe_o), .frame_sync_i(frame_sync_i), .frame_sync_o(frame_sync_o),
		.frame_sync_oe_o(frame_sync_oe_o), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
		.tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .busy_o(busy_o),
		.video_locked_o(video_locked_o), .frame_done_o(frame_done_o), .overrun_o(overrun_o), .underrun_o(underrun_o));
	pvp_src_model u_pvp_src_model (.pclk_o(port_sample_clock_i), .data_o(port_data_i), .fs_o(frame_sync_i));
	always #10 clk_i = ~clk_i;
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (rx_valid_o === 1'b1 && rx_ready_i) rxq.push_back(rx_data_o);
		if (shown_q) txq.push_back(port_data_o);
		if (frame_done_o === 1'b1) n_done++;
		if (tx_ready_o === 1'b1 && tx_valid_i) tx_data_i <= tx_data_i + 16'h0111;
		shown_q <= tx_ready_o === 1'b1 && tx_valid_i;
		fs_prev_q <= frame_sync_o;
		if (frame_sync_o[0] === 1'b1 && !fs_prev_q[0]) n_hs++;
		if (frame_sync_o[1] === 1'b1 && !fs_prev_q[1]) n_vs++;
		if (frame_sync_o[2] === 1'b1 && !fs_prev_q[2]) n_fe++;
		if (cyc == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// mode and counts change only with the port disabled, which also clears sticky flags
	task automatic cfg(input logic [1:0] m, input logic [2:0] w, input logic [15:0] d, input logic [15:0] n,
		input logic [15:0] l, input logic [1:0] sub);
		@(posedge clk_i);
		enable_i <= 1'b0;
		port_mode_i <= m;
		data_width_i <= w;
		sync_to_data_delay_i <= d;
		transfer_sample_count_i <= n;
		frame_line_count_i <= l;
		video_submode_i <= sub;
		repeat (2) @(posedge clk_i);
		enable_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		#5;
		rxq.delete();
		txq.delete();
		n_done = 0;
		n_hs = 0;
		n_vs = 0;
		n_fe = 0;
	endtask
	// ones word is all-ones at the sample width; 10-bit samples carry the 8-bit view in bits 9:2
	function automatic logic [15:0] vword(input logic [7:0] v, input logic t);
		vword = (v == 8'hFF) ? (t ? 16'h03FF : 16'h00FF) : (t ? {6'h00, v, 2'b00} : {8'h00, v});
	endfunction
	task automatic run_in(input logic [2:0] w, input logic [15:0] d, input logic [15:0] n, input logic fill);
		logic [15:0] mask;
		mask = (w == 3'h0) ? 16'h00FF : (16'hFFFF >> (3'h7 - w));
		cfg(`PVP_MODE_IN, w, d, n, 16'h1, 2'h0);
		rx_ready_i <= !fill;
		u_pvp_src_model.tick(16'hA5A5, 1'b0, 0);
		u_pvp_src_model.tick(16'h5A5A, 1'b1, 0);
		for (int i = 0; i < d; i++) u_pvp_src_model.tick(16'hC3C3, 1'b0, 0);
		for (int i = 0; i < n; i++) u_pvp_src_model.tick(16'hFFF0 + i, 1'b0, i * 40);
		u_pvp_src_model.tick(16'h3C3C, 1'b0, 0);
		u_pvp_src_model.release_bus();
		repeat (8) @(posedge clk_i);
		chk("overrun", overrun_o, fill);
		rx_ready_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		chk("rx count", 16'(rxq.size()), fill ? 16'h8 : n);
		chk("frame done", 16'(n_done), 16'h1);
		for (int i = 0; i < rxq.size(); i++) chk("rx word", rxq[i], (16'hFFF0 + i) & mask);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_i);
		reset_n_i <= 1'b1;
		run_in(3'h0, 16'h2, 16'h4, 1'b0);
		run_in(3'h7, 16'h0, 16'h3, 1'b0);
		run_in(3'h1, 16'h1, 16'hA, 1'b1);
		$display("test input done");
		cfg(`PVP_MODE_OUT, 3'h7, 16'h1, 16'h3, 16'h1, 2'h0);
		tx_valid_i <= 1'b1;
		chk("data oe", port_data_oe_o, 1'b1);
		chk("sync oe", frame_sync_oe_o, 3'h7);
		repeat (6) u_pvp_src_model.tick(16'h0000, 1'b0, 0);
		tx_valid_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("tx count", 16'(txq.size()), 16'h3);
		for (int k = 0; k < 3; k++) chk("tx word", txq[k], 16'h1234 + 16'h0111 * k);
		chk("underrun", underrun_o, 1'b0);
		chk("out done", 16'(n_done), 16'h1);
		chk("out hsync", 16'(n_hs), 16'h2);
		chk("out vsync", 16'(n_vs), 16'h2);
		chk("out window", 16'(n_fe), 16'h1);
		repeat (2) u_pvp_src_model.tick(16'h0000, 1'b0, 0);
		repeat (4) @(posedge clk_i);
		chk("underrun set", underrun_o, 1'b1);
		$display("test output done");
		// two lines of two samples; sync ticks carry no data
		cfg(`PVP_MODE_CAPTURE, 3'h0, 16'h0, 16'h2, 16'h2, 2'h0);
		chk("cap data oe", port_data_oe_o, 1'b0);
		chk("cap sync oe", frame_sync_oe_o, 3'h3);
		for (int k = 0; k < 6; k++) u_pvp_src_model.tick(16'h0100 + k, 1'b0, 0);
		u_pvp_src_model.release_bus();
		repeat (8) @(posedge clk_i);
		chk("cap count", 16'(rxq.size()), 16'h4);
		for (int k = 0; k < 4; k++) chk("cap word", rxq[k], 16'(k + 1 + k / 2));
		chk("cap done", 16'(n_done), 16'h1);
		chk("cap hsync", 16'(n_hs), 16'h2);
		chk("cap vsync", 16'(n_vs), 16'h1);
		$display("test capture done");
		// same stream twice: whole field, then active samples only
		for (int s = 0; s < 2; s++) begin
			cfg(`PVP_MODE_ITU, 3'h0, 16'h0, 16'h5, 16'h1, s ? `PVP_ITU_ACTIVE : `PVP_ITU_FIELD);
			for (int k = 0; k < 21; k++) u_pvp_src_model.tick({8'h00, VS[k]}, 1'b0, 0);
			u_pvp_src_model.release_bus();
			repeat (8) @(posedge clk_i);
			chk("locked", video_locked_o, 1'b1);
			chk("busy", busy_o, 1'b1);
			for (int k = 0; k < (s ? 4 : 8); k++) chk("video word", rxq[k], {8'h00, VS[k + (s ? 14 : 7)]});
		end
		// blanking-only mode at both sample widths
		for (int t = 0; t < 2; t++) begin
			video_ten_bit_i <= t[0];
			cfg(`PVP_MODE_ITU, 3'h0, 16'h0, 16'h5, 16'h1, `PVP_ITU_VBI);
			for (int k = 0; k < 19; k++) u_pvp_src_model.tick(vword(VB[k], t[0]), 1'b0, 0);
			u_pvp_src_model.release_bus();
			repeat (8) @(posedge clk_i);
			chk("vbi count", 16'(rxq.size()), 16'h4);
			for (int k = 0; k < 4; k++) chk("vbi word", rxq[k], vword(VB[k + 8], t[0]));
		end
		$display("test video done");
		tally_and_finish();
	end
endmodule
